//--- design/afe_top.sv
// ascii frame engine: apb registers, transmit framing, receive framing, ring buffer
`timescale 1ns/1ps
`include "afe_defs.svh"
module afe_top (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // line transmit characters
    output logic      [7:0]  tx_data,
    output logic             tx_valid,
    input  wire logic        tx_ready,
    // line receive characters
    input  wire logic [7:0]  rx_data,
    input  wire logic        rx_valid,
    // half duplex direction, high while sending
    output logic             line_tx_en
);
    function automatic logic is_end(input logic two, input logic [7:0] p, input logic [7:0] c,
                                    input logic [7:0] d1, input logic [7:0] d2);
        is_end = two ? (p == d1 && c == d2) : (c == d1);
    endfunction
    // registers
    logic [8:0]  ctrl_q;
    logic [15:0] delim_q, flow_q, tmo_q;
    logic [11:0] fixlen_q;
    logic [7:0]  maxfr_q;
    logic [3:0]  err_q;
    logic [31:0] prdata_q;
    logic        pready_q, pslverr_q;
    logic [7:0]  tx_mem [0:255];
    logic [7:0]  rx_mem [0:4095];
    logic [12:0] flen [0:255];
    logic [7:0]  txw_q, idx_q;
    logic [8:0]  cnt_q;
    logic [16:0] gap_q;
    logic        hit_q, app_q, txv_q, paused_q, ltx_q;
    logic [7:0]  txd_q;
    afe_pkg::afe_tx_t st_q;
    logic [12:0] wbase_q, rd_q, clen_q, roff_q;
    logic [15:0] idle_q;
    logic        act_q;
    logic [7:0]  prev_q, fw_q, fr_q, fcnt_q;
    // configuration decode
    wire afe_pkg::afe_mode_t mode = afe_pkg::afe_mode_t'(ctrl_q[1:0]);
    wire afe_pkg::afe_sopt_t sopt = afe_pkg::afe_sopt_t'(ctrl_q[3:2]);
    wire       two   = ctrl_q[`AFE_B_TWO];
    wire       prot  = ctrl_q[`AFE_B_PROT];
    wire       nogap = ctrl_q[`AFE_B_NOGAP];
    wire       flow  = ctrl_q[`AFE_B_FLOW];
    wire       hdx   = ctrl_q[`AFE_B_HDX];
    wire [7:0] d1 = delim_q[7:0];
    wire [7:0] d2 = delim_q[15:8];
    wire [7:0] fres = flow_q[7:0];
    wire [7:0] fpau = flow_q[15:8];

    // apb decode; a transfer completes in its second access cycle
    wire acc   = psel && penable && !pready_q;
    wire fin   = psel && penable && pready_q;
    wire wr    = fin && pwrite;
    wire rd    = fin && !pwrite;
    wire a_ctl = paddr == `AFE_A_CTRL;
    wire a_dlm = paddr == `AFE_A_DELIM;
    wire a_flw = paddr == `AFE_A_FLOW;
    wire a_tmo = paddr == `AFE_A_TMO;
    wire a_fix = paddr == `AFE_A_FIXLEN;
    wire a_mfr = paddr == `AFE_A_MAXFR;
    wire a_txd = paddr == `AFE_A_TXDATA;
    wire a_cmd = paddr == `AFE_A_TXCMD;
    wire a_rst = paddr == `AFE_A_RXSTAT;
    wire a_rxd = paddr == `AFE_A_RXDATA;
    wire a_err = paddr == `AFE_A_ERR;
    wire mapped = a_ctl | a_dlm | a_flw | a_tmo | a_fix | a_mfr | a_txd | a_cmd | a_rst | a_rxd | a_err;
    wire [12:0] head_len = flen[fr_q];
    wire        have = fcnt_q != 8'h00;
    wire [31:0] rmux = a_ctl ? {23'h000000, ctrl_q} :
                       a_dlm ? {16'h0000, delim_q} :
                       a_flw ? {16'h0000, flow_q} :
                       a_tmo ? {16'h0000, tmo_q} :
                       a_fix ? {20'h00000, fixlen_q} :
                       a_mfr ? {24'h000000, maxfr_q} :
                       a_cmd ? {31'h00000000, st_q != afe_pkg::AFE_T_IDLE} :
                       a_rst ? {3'h0, head_len, 8'h00, fcnt_q} :
                       a_rxd ? {31'h00000000, have} << 8 | {24'h000000, rx_mem[rd_q[11:0]]} :
                       a_err ? {28'h0000000, err_q} : 32'h00000000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h00000000;
        end else begin
            pready_q  <= acc;
            pslverr_q <= acc && !mapped;
            prdata_q  <= acc ? rmux : 32'h00000000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q   <= 9'h000;
            delim_q  <= 16'h0000;
            flow_q   <= `AFE_R_FLOW;
            tmo_q    <= `AFE_R_TMO;
            fixlen_q <= `AFE_R_FIXLEN;
            maxfr_q  <= `AFE_R_MAXFR;
        end else if (wr) begin
            if (a_ctl) ctrl_q <= pwdata[8:0];
            if (a_dlm) delim_q <= pwdata[15:0];
            if (a_flw) flow_q <= pwdata[15:0];
            if (a_tmo) tmo_q <= pwdata[15:0];
            if (a_fix) fixlen_q <= pwdata[11:0];
            // frame limit clamped to 1..250
            if (a_mfr) maxfr_q <= (pwdata[7:0] == 8'h00) ? 8'h01 :
                                  (pwdata[7:0] > `AFE_R_MAXFR) ? `AFE_R_MAXFR : pwdata[7:0];
        end
    end

    // transmit side
    wire       go     = wr && a_cmd && pwdata[`AFE_B_GO];
    wire       tx_idle = st_q == afe_pkg::AFE_T_IDLE;
    wire [7:0] b      = tx_mem[idx_q];
    wire       done   = {1'b0, idx_q} == cnt_q || hit_q || cnt_q[8];
    wire       take   = !txv_q || tx_ready;
    wire       gap_ok = (mode == afe_pkg::AFE_M_TMO) ? (gap_q > {1'b0, tmo_q}) :
                        (mode == afe_pkg::AFE_M_FIX) ? (nogap || gap_q >= {1'b0, tmo_q}) :
                        1'b1;
    wire       fl_chr = flow && (b == fres || b == fpau);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q  <= afe_pkg::AFE_T_IDLE;
            txw_q <= 8'h00;
            idx_q <= 8'h00;
            cnt_q <= 9'h000;
            hit_q <= 1'b0;
            app_q <= 1'b0;
            txv_q <= 1'b0;
            txd_q <= 8'h00;
        end else begin
            if (wr && a_txd) txw_q <= txw_q + 8'h01;
            case (st_q)
                afe_pkg::AFE_T_IDLE: begin
                    if (go) begin
                        st_q  <= afe_pkg::AFE_T_GAP;
                        cnt_q <= {1'b0, pwdata[7:0]};
                        idx_q <= 8'h00;
                        hit_q <= 1'b0;
                        app_q <= 1'b0;
                        txw_q <= 8'h00;
                    end
                end
                afe_pkg::AFE_T_GAP: begin
                    if (gap_ok) st_q <= afe_pkg::AFE_T_SEND;
                end
                afe_pkg::AFE_T_SEND: begin
                    if (take) begin
                        if (done) begin
                            txv_q <= 1'b0;
                            st_q  <= (sopt == afe_pkg::AFE_S_APP) ? afe_pkg::AFE_T_APP : afe_pkg::AFE_T_IDLE;
                        end else if (!paused_q) begin
                            txv_q <= 1'b1;
                            txd_q <= b;
                            idx_q <= idx_q + 8'h01;
                            // later bytes dropped once the end sequence has gone out
                            hit_q <= mode == afe_pkg::AFE_M_DLM && sopt == afe_pkg::AFE_S_STOP &&
                                     is_end(two && idx_q != 8'h00, txd_q, b, d1, d2);
                        end else begin
                            txv_q <= 1'b0;
                        end
                    end
                end
                afe_pkg::AFE_T_APP: begin
                    if (take) begin
                        if (app_q && (!two || txd_q == d2) && txv_q) begin
                            txv_q <= 1'b0;
                            st_q  <= afe_pkg::AFE_T_IDLE;
                        end else if (!paused_q) begin
                            txv_q <= 1'b1;
                            txd_q <= app_q ? d2 : d1;
                            app_q <= 1'b1;
                        end else begin
                            txv_q <= 1'b0;
                        end
                    end
                end
                default: st_q <= afe_pkg::AFE_T_IDLE;
            endcase
        end
    end

    // gap counter runs since the last frame's final character was taken; saturates
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap_q <= 17'h1ffff;
            ltx_q <= 1'b0;
        end else begin
            if (st_q == afe_pkg::AFE_T_SEND || st_q == afe_pkg::AFE_T_APP) gap_q <= 17'h00000;
            else if (gap_q != 17'h1ffff) gap_q <= gap_q + 17'h00001;
            // direction follows the sender within one cycle, far inside the switch limit
            ltx_q <= hdx && !tx_idle && st_q != afe_pkg::AFE_T_GAP;
        end
    end

    // receive side; own echo ignored while driving a half duplex line
    wire rx_ok  = rx_valid && !ltx_q;
    wire is_fc  = flow && (rx_data == fres || rx_data == fpau);
    wire rx_chr = rx_ok && !is_fc;
    wire expire = act_q && !rx_ok && idle_q >= tmo_q;
    wire [12:0] nlen  = clen_q + 13'h0001;
    wire [12:0] occ   = wbase_q + clen_q - rd_q;
    wire        room  = occ < `AFE_BUF_BYTES;
    wire        cl_dl = mode == afe_pkg::AFE_M_DLM && is_end(two && clen_q != 13'h0000, prev_q, rx_data, d1, d2);
    wire        cl_fx = mode == afe_pkg::AFE_M_FIX && nlen[11:0] == fixlen_q && nlen[12] == 1'b0;
    wire        close = (rx_chr && room && (cl_dl || cl_fx)) ||
                        (expire && mode == afe_pkg::AFE_M_TMO && clen_q != 13'h0000);
    wire        abort = expire && mode != afe_pkg::AFE_M_TMO && clen_q != 13'h0000;
    wire        ovf_b = rx_chr && !room;
    wire [12:0] flen_n = (rx_chr && room) ? nlen : clen_q;
    wire        full  = fcnt_q >= maxfr_q;
    wire        push  = close && !(full && prot);
    wire        drop  = close && full && !prot && have;
    wire        pop   = rd && a_rxd && have && !drop;
    wire        last  = roff_q + 13'h0001 == head_len;
    wire        fr_adv = drop || (pop && last);
    // buffers need no reset, pointers guard every read
    always_ff @(posedge pclk) begin
        if (wr && a_txd) tx_mem[txw_q] <= pwdata[7:0];
        if (rx_chr && room) rx_mem[wbase_q[11:0] + clen_q[11:0]] <= rx_data;
        if (push) flen[fw_q] <= flen_n;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idle_q   <= 16'h0000;
            act_q    <= 1'b0;
            prev_q   <= 8'h00;
            paused_q <= 1'b0;
        end else begin
            if (rx_ok) begin
                idle_q <= 16'h0000;
                act_q  <= 1'b1;
            end else if (expire) begin
                act_q <= 1'b0;
            end else if (act_q) begin
                idle_q <= idle_q + 16'h0001;
            end
            if (rx_chr) prev_q <= rx_data;
            if (!flow) paused_q <= 1'b0;
            else if (rx_ok && rx_data == fpau) paused_q <= 1'b1;
            else if (rx_ok && rx_data == fres) paused_q <= 1'b0;
        end
    end

    // bytes after a close start the next frame; a timeout before the next close
    // discards them, so merge and discard fall out of one accumulator
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wbase_q <= 13'h0000;
            clen_q  <= 13'h0000;
        end else begin
            if (push) begin
                wbase_q <= wbase_q + flen_n;
                clen_q  <= 13'h0000;
            end else if (close || abort || ovf_b) begin
                clen_q <= 13'h0000;
            end else if (rx_chr) begin
                clen_q <= nlen;
            end
        end
    end

    // frame queue, oldest first; overwrite drops the oldest whole frame
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_q   <= 13'h0000;
            roff_q <= 13'h0000;
            fw_q   <= 8'h00;
            fr_q   <= 8'h00;
            fcnt_q <= 8'h00;
        end else begin
            if (drop) begin
                rd_q   <= rd_q + head_len - roff_q;
                roff_q <= 13'h0000;
            end else if (pop) begin
                rd_q   <= rd_q + 13'h0001;
                roff_q <= last ? 13'h0000 : roff_q + 13'h0001;
            end
            if (push) fw_q <= fw_q + 8'h01;
            if (fr_adv) fr_q <= fr_q + 8'h01;
            fcnt_q <= fcnt_q + {7'h00, push} - {7'h00, fr_adv};
        end
    end

    // sticky errors, write one to clear, a new event wins over the clear
    wire [3:0] ev = {go && !tx_idle,
                     st_q == afe_pkg::AFE_T_SEND && take && !done && !paused_q && fl_chr,
                     ovf_b || (close && full && prot),
                     abort};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) err_q <= 4'h0;
        else err_q <= (err_q & ~((wr && a_err) ? pwdata[3:0] : 4'h0)) | ev;
    end

    assign prdata     = prdata_q;
    assign pready     = pready_q;
    assign pslverr    = pslverr_q;
    assign tx_data    = txd_q;
    assign tx_valid   = txv_q;
    assign line_tx_en = ltx_q;
    chk_gap_tmo: assert property (@(posedge pclk) disable iff (!presetn)
        st_q == afe_pkg::AFE_T_GAP && mode == afe_pkg::AFE_M_TMO && gap_q <= {1'b0, tmo_q}
        |=> st_q == afe_pkg::AFE_T_GAP) else $error("send started before timeout gap");
    chk_gap_fixed: assert property (@(posedge pclk) disable iff (!presetn)
        st_q == afe_pkg::AFE_T_GAP && mode == afe_pkg::AFE_M_FIX && !nogap && gap_q < {1'b0, tmo_q}
        |=> st_q == afe_pkg::AFE_T_GAP) else $error("fixed mode gap too short");
    chk_stop_delim: assert property (@(posedge pclk) disable iff (!presetn)
        st_q == afe_pkg::AFE_T_SEND && hit_q |=> $stable(idx_q)) else $error("byte sent after delimiter");
    chk_append_d1: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(st_q == afe_pkg::AFE_T_APP) ##1 (txv_q && !paused_q) |-> txd_q == d1)
        else $error("appended delimiter wrong");
    chk_tmo_close: assert property (@(posedge pclk) disable iff (!presetn)
        expire && mode == afe_pkg::AFE_M_TMO && clen_q != 13'h0000 && !(full && prot)
        |=> fcnt_q == $past(fcnt_q) + 8'h01 - {7'h00, $past(fr_adv)}) else $error("timeout frame not stored");
    chk_abort_err: assert property (@(posedge pclk) disable iff (!presetn)
        abort |=> err_q[`AFE_E_RXTMO] && clen_q == 13'h0000) else $error("partial frame not aborted");
    chk_fixed_len: assert property (@(posedge pclk) disable iff (!presetn)
        push && mode == afe_pkg::AFE_M_FIX |-> flen_n[11:0] == fixlen_q) else $error("fixed frame wrong length");
    chk_idle_rst: assert property (@(posedge pclk) disable iff (!presetn)
        rx_ok |=> idle_q == 16'h0000 && act_q) else $error("timeout not restarted");
    chk_line_dir: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(tx_idle) |-> ##[1:2] !ltx_q) else $error("direction switch too slow");
    chk_frame_lim: assert property (@(posedge pclk) disable iff (!presetn)
        fcnt_q <= maxfr_q || $past(wr && a_mfr, 2)) else $error("frame limit exceeded");
endmodule

//--- design/afe_defs.svh
// register map, field positions, reset values and timing for the frame engine
`ifndef AFE_DEFS_SVH
`define AFE_DEFS_SVH
`define AFE_A_CTRL    8'h00
`define AFE_A_DELIM   8'h04
`define AFE_A_FLOW    8'h08
`define AFE_A_TMO     8'h0c
`define AFE_A_FIXLEN  8'h10
`define AFE_A_MAXFR   8'h14
`define AFE_A_TXDATA  8'h18
`define AFE_A_TXCMD   8'h1c
`define AFE_A_RXSTAT  8'h20
`define AFE_A_RXDATA  8'h24
`define AFE_A_ERR     8'h28
`define AFE_B_TWO     4
`define AFE_B_PROT    5
`define AFE_B_NOGAP   6
`define AFE_B_FLOW    7
`define AFE_B_HDX     8
`define AFE_B_GO      31
`define AFE_R_FLOW    16'h1311
`define AFE_R_MAXFR   8'hfa
`define AFE_R_TMO     16'h0064
`define AFE_R_FIXLEN  12'h010
`define AFE_BUF_BYTES 13'h1000
`define AFE_E_RXTMO   0
`define AFE_E_RXOVF   1
`define AFE_E_TXFLOW  2
`define AFE_E_TXBUSY  3
`define AFE_CLK_NS    50
`define AFE_SW_NS     1000000
`define AFE_SW_CYC    (`AFE_SW_NS / `AFE_CLK_NS)
`endif

//--- design/afe_pkg.sv
// types shared by the frame engine
package afe_pkg;
    typedef enum logic [1:0] {
        AFE_M_TMO = 2'h0,
        AFE_M_DLM = 2'h1,
        AFE_M_FIX = 2'h2
    } afe_mode_t;
    typedef enum logic [1:0] {
        AFE_S_STOP = 2'h0,
        AFE_S_EXACT = 2'h1,
        AFE_S_APP = 2'h2
    } afe_sopt_t;
    typedef enum logic [3:0] {
        AFE_T_IDLE = 4'h1,
        AFE_T_GAP  = 4'h2,
        AFE_T_SEND = 4'h4,
        AFE_T_APP  = 4'h8
    } afe_tx_t;
endpackage

//--- dv/afe_line_partner.sv
// line partner model: takes transmit characters and sends receive characters
`timescale 1ns/1ps
module afe_line_partner (
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // characters from the engine
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_valid,
    input  wire logic       line_tx_en,
    output logic            tx_ready,
    // characters to the engine
    output logic      [7:0] rx_data,
    output logic            rx_valid
);
    logic       slow;
    int         cyc;
    logic [7:0] txq[$];
    int         txt[$];
    logic       txen[$];
    initial begin
        tx_ready = 1'b0;
        rx_valid = 1'b0;
        rx_data  = 8'hff;
        slow     = 1'b0;
        cyc      = 0;
    end
    // slow mode refuses half the cycles, like a busy partner
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
            txq.push_back(tx_data);
            txt.push_back(cyc);
            txen.push_back(line_tx_en);
        end
        tx_ready <= presetn && (!slow || cyc[1]);
    end
    // one character; the released line shows inverted data, not the old value
    task automatic send(input logic [7:0] b);
        @(posedge pclk);
        rx_valid <= 1'b1;
        rx_data  <= b;
        @(posedge pclk);
        rx_valid <= 1'b0;
        rx_data  <= ~b;
    endtask
endmodule

//--- dv/ascii_frame_engine_test.sv
// self-checking bench for the frame engine over apb and a line partner
`timescale 1ns/1ps
module ascii_frame_engine_test;
    logic        pclk, presetn, psel, penable, pwrite, sv;
    logic [7:0]  paddr, tx_data, rx_data;
    logic [31:0] pwdata, prdata, rdv;
    logic        pready, pslverr, tx_valid, tx_ready, rx_valid, line_tx_en;
    int          miscompares, checked, cycles;
    afe_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data),
        .rx_valid(rx_valid), .line_tx_en(line_tx_en));
    afe_line_partner partner_u (.pclk(pclk), .presetn(presetn), .tx_data(tx_data), .tx_valid(tx_valid),
        .line_tx_en(line_tx_en), .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid));
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    // hang guard, the run needs a few thousand cycles
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            conclude();
        end
    end
    task automatic conclude();
        $display("counts: %0d checked, %0d miscompares", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    // request held until pready is seen high at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rdv = prdata;
        sv  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input string n, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(n, e, rdv & m);
    endtask
    // bytes loaded first, then go; waits for busy to drop
    task automatic txf(input logic [7:0] b[$], input logic [7:0] n, input logic [7:0] e[$]);
        int base;
        base = partner_u.txq.size();
        foreach (b[i]) apb(1'b1, 8'h18, {24'h0, b[i]});
        apb(1'b1, 8'h1c, {1'b1, 23'h0, n});
        do apb(1'b0, 8'h1c, 32'h0); while (rdv[0] === 1'b1);
        chk("tx count", e.size(), partner_u.txq.size() - base);
        foreach (e[i]) chk("tx byte", {24'h0, e[i]}, {24'h0, partner_u.txq[base + i]});
    endtask
    function automatic int lastgap();
        return partner_u.txt[$] - partner_u.txt[$ - 1];
    endfunction
    task automatic sendq(input logic [7:0] b[$]);
        foreach (b[i]) partner_u.send(b[i]);
    endtask
    // timeout is 40 cycles, so 48 idle cycles always close or abort
    task automatic idle();
        repeat (48) @(posedge pclk);
    endtask
    task automatic rxf(input logic [7:0] e[$]);
        rd("rx length", 8'h20, 32'h1fff0000, {3'h0, 13'(e.size()), 16'h0});
        foreach (e[i]) rd("rx byte", 8'h24, 32'h1ff, {23'h0, 1'b1, e[i]});
    endtask
    task automatic done(input string n);
        $display("test %s finished", n);
    endtask
    initial begin
        presetn = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h0;
        pwdata  = 32'h0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rd("flow chars", 8'h08, 32'hffff, 32'h1311);
        rd("max frames", 8'h14, 32'hff, 32'hfa);
        rd("fixed len", 8'h10, 32'hfff, 32'h10);
        rd("unmapped", 8'h3c, 32'hffffffff, 32'h0);
        chk("slave error", 32'h1, {31'h0, sv});
        apb(1'b1, 8'h0c, 32'h28);
        apb(1'b1, 8'h04, 32'h0a0d);
        done("defaults");
        txf('{8'h01, 8'h02, 8'h03}, 8'h3, '{8'h01, 8'h02, 8'h03});
        txf('{8'h04}, 8'h1, '{8'h04});
        chk("tx pause", 1, {31'h0, lastgap() > 40});
        partner_u.slow = 1'b1;
        apb(1'b1, 8'h00, 32'h1);
        txf('{8'h41, 8'h0d, 8'h42}, 8'h3, '{8'h41, 8'h0d});
        apb(1'b1, 8'h00, 32'h5);
        txf('{8'h41, 8'h42, 8'h0d}, 8'h3, '{8'h41, 8'h42, 8'h0d});
        apb(1'b1, 8'h00, 32'h9);
        txf('{8'h43}, 8'h1, '{8'h43, 8'h0d});
        apb(1'b1, 8'h00, 32'h19);
        txf('{8'h44, 8'h45}, 8'h2, '{8'h44, 8'h45, 8'h0d, 8'h0a});
        partner_u.slow = 1'b0;
        apb(1'b1, 8'h00, 32'h2);
        txf('{8'h05, 8'h06}, 8'h2, '{8'h05, 8'h06});
        txf('{8'h07}, 8'h1, '{8'h07});
        chk("fixed gap", 1, {31'h0, lastgap() >= 40});
        apb(1'b1, 8'h00, 32'h42);
        txf('{8'h08}, 8'h1, '{8'h08});
        chk("gap off", 1, {31'h0, lastgap() < 40});
        apb(1'b1, 8'h00, 32'h100);
        txf('{8'h09}, 8'h1, '{8'h09});
        chk("dir send", 1, {31'h0, partner_u.txen[$]});
        chk("dir recv", 0, {31'h0, line_tx_en});
        done("transmit");
        apb(1'b1, 8'h00, 32'h0);
        sendq('{8'h21, 8'h0d, 8'h23});
        idle();
        rxf('{8'h21, 8'h0d, 8'h23});
        sendq('{8'h31});
        repeat (30) @(posedge pclk);
        sendq('{8'h32});
        idle();
        rxf('{8'h31, 8'h32});
        sendq('{8'h41});
        idle();
        sendq('{8'h42, 8'h43});
        idle();
        rd("frames", 8'h20, 32'hff, 32'h2);
        rxf('{8'h41});
        rxf('{8'h42, 8'h43});
        apb(1'b1, 8'h00, 32'h1);
        sendq('{8'h61, 8'h0d, 8'h62});
        idle();
        rxf('{8'h61, 8'h0d});
        apb(1'b1, 8'h28, 32'hf);
        sendq('{8'h63});
        idle();
        rd("abort flag", 8'h28, 32'h1, 32'h1);
        rd("frames", 8'h20, 32'hff, 32'h0);
        sendq('{8'h64});
        sendq('{8'h65, 8'h0d});
        idle();
        rxf('{8'h64, 8'h65, 8'h0d});
        done("delimiter");
        apb(1'b1, 8'h10, 32'h3);
        apb(1'b1, 8'h00, 32'h2);
        sendq('{8'h71, 8'h72, 8'h73, 8'h74});
        idle();
        rxf('{8'h71, 8'h72, 8'h73});
        apb(1'b1, 8'h28, 32'hf);
        sendq('{8'h75, 8'h76});
        idle();
        rd("abort flag", 8'h28, 32'h1, 32'h1);
        rd("frames", 8'h20, 32'hff, 32'h0);
        apb(1'b1, 8'h00, 32'h0);
        apb(1'b1, 8'h14, 32'h1);
        sendq('{8'h81});
        idle();
        sendq('{8'h82});
        idle();
        rd("frames", 8'h20, 32'hff, 32'h1);
        rxf('{8'h82});
        apb(1'b1, 8'h00, 32'h80);
        txf('{8'h11}, 8'h1, '{8'h11});
        rd("flow flag", 8'h28, 32'h4, 32'h4);
        sendq('{8'h21, 8'h11, 8'h22});
        idle();
        rxf('{8'h21, 8'h22});
        apb(1'b1, 8'h00, 32'h20);
        sendq('{8'h91});
        idle();
        sendq('{8'h92});
        idle();
        rd("frames", 8'h20, 32'hff, 32'h1);
        rd("protect flag", 8'h28, 32'h2, 32'h2);
        rxf('{8'h91});
        apb(1'b1, 8'h00, 32'h11);
        sendq('{8'h51, 8'h0d, 8'h0a});
        idle();
        rxf('{8'h51, 8'h0d, 8'h0a});
        done("receive");
        conclude();
    end
endmodule
